// ===== tb/dsdom_mod_model.sv
// Purpose: behavioural modulator on mod_bit
// Assumes: the path offset alone drives full scale positive
// Notes: level is a constant source density
module dsdom_mod_model (
  // Clock
  input wire logic pclk,
  // Controls from the block
  input wire logic input_short,
  input wire logic input_invert,
  // Source and bit stream
  input wire logic level,
  output logic mod_bit
);
  initial mod_bit = 1'h0;
  always @(posedge pclk) begin
    mod_bit <= input_short ? 1'h1 : level ^ input_invert;
  end
endmodule : dsdom_mod_model

// ===== tb/dsdom_props.sv
// Purpose: port checks for dsdom_top
// Assumes: one clock, presetn active low
// Notes: shadows follow the last gain and setup writes
`include "dsdom_consts.svh"
module dsdom_props #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Analog controls
  input wire logic [3:0] input_gain_en,
  input wire logic [1:0] ref_gain_en,
  input wire logic converter_enable,
  input wire logic input_short,
  input wire logic input_invert,
  // Fast stream
  input wire logic fast_valid,
  input wire logic [`DSDOM_RESULT_W-1:0] fast_data,
  input wire logic fast_ready
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr_gain;
  logic wr_setup;
  logic [7:0] gain_sh;
  logic [1:0] mode_sh;
  logic [9:0] idle_cnt;
  assign wr_gain = psel && penable && pready && pwrite && paddr == ADDR_W'(`DSDOM_OFS_GAIN);
  assign wr_setup = psel && penable && pready && pwrite && paddr == ADDR_W'(`DSDOM_OFS_SETUP);
  ////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_sh <= 8'h00;
    end else if (wr_gain) begin
      gain_sh <= pwdata[7:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sh <= 2'h0;
    end else if (wr_setup) begin
      mode_sh <= pwdata[1:0];
    end
  end
  // Silence this long means a stuck filter; three 256-tap windows plus slack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt <= 10'h000;
    end else if (fast_valid || wr_setup || !converter_enable) begin
      idle_cnt <= 10'h000;
    end else begin
      idle_cnt <= idle_cnt + 10'h001;
    end
  end
  AST_PREADY_WAIT: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_SLVERR_MAP: assert property (pready |-> pslverr == (paddr > ADDR_W'(`DSDOM_OFS_STATUS)))
    else $error("pslverr wrong");
  AST_GAIN_INPUT: assert property (wr_gain |-> ##2 input_gain_en == gain_sh[3:0])
    else $error("input gain wrong");
  AST_GAIN_REF: assert property (wr_gain |-> ##2 ref_gain_en == gain_sh[5:4])
    else $error("ref gain wrong");
  AST_GAIN_ENABLE: assert property (wr_gain |-> ##2 converter_enable == gain_sh[7])
    else $error("enable wrong");
  AST_SHORT_MODE: assert property (wr_setup |-> ##3 input_short == (mode_sh == 2'h0))
    else $error("short wrong");
  AST_INVERT_OFF: assert property (wr_setup && pwdata[1:0] != 2'h1 |-> ##3 !input_invert)
    else $error("invert outside chop");
  AST_FAST_HOLD: assert property (fast_valid && !fast_ready |=> fast_valid && $stable(fast_data))
    else $error("fast word lost");
  AST_FAST_PERIOD: assert property (idle_cnt <= 10'h316)
    else $error("fast stream stuck");
endmodule : dsdom_props
bind dsdom_top dsdom_props #(.ADDR_W(ADDR_W)) i_dsdom_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .input_gain_en(input_gain_en),
  .ref_gain_en(ref_gain_en), .converter_enable(converter_enable),
  .input_short(input_short), .input_invert(input_invert), .fast_valid(fast_valid),
  .fast_data(fast_data), .fast_ready(fast_ready));

// ===== tb/dsdom_top_test.sv
// Purpose: self-checking bench for dsdom_top
// Assumes: tap code 00 keeps windows short
// Notes: slow gaps come from polling, hence a tolerance
module dsdom_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mod_bit, level, err;
  logic converter_enable, input_short, input_invert, fast_valid, fast_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] input_gain_en;
  logic [1:0] ref_gain_en;
  logic [23:0] fast_data, v;
  int num_errors = 0, total_checks = 0, cyc = 0, t0, t1;
  dsdom_top i_dsdom_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .mod_bit(mod_bit), .input_gain_en(input_gain_en),
    .ref_gain_en(ref_gain_en), .converter_enable(converter_enable),
    .input_short(input_short), .input_invert(input_invert), .fast_valid(fast_valid),
    .fast_data(fast_data), .fast_ready(fast_ready));
  dsdom_mod_model i_dsdom_mod_model (.pclk(pclk), .input_short(input_short),
    .input_invert(input_invert), .level(level), .mod_bit(mod_bit));
  ////////////////////////////////////////
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      check(32'h0, 32'h1);
      summarize;
    end
  endtask : apb
  task automatic take;
    int n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!(fast_valid === 1'h1 && fast_ready === 1'h1) && n < 4000);
    v = fast_data;
    if (fast_valid !== 1'h1 || fast_ready !== 1'h1) begin
      check(32'h0, 32'h1);
      summarize;
    end
  endtask : take
  task automatic wait_slow(output int t);
    int n = 0;
    do begin
      apb(1'h0, 12'h010, 32'h0);
      n++;
    end while (rd[0] !== 1'h1 && n < 8000);
    if (rd[0] !== 1'h1) begin
      check(32'h0, 32'h1);
      summarize;
    end
    t = cyc;
    apb(1'h0, 12'h008, 32'h0);
  endtask : wait_slow
  task automatic t_regs;
    logic [7:0] g [4] = '{8'h13, 8'hB7, 8'hB8, 8'hFF};
    apb(1'h0, 12'h000, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, 12'h004, 32'h0);
    check(rd, 32'h0);
    foreach (g[i]) begin
      apb(1'h1, 12'h000, 32'(g[i]));
      repeat (2) @(posedge pclk);
      check(32'({ref_gain_en, input_gain_en}), 32'(g[i][5:0]));
      check(32'(converter_enable), 32'(g[i][7]));
      apb(1'h0, 12'h000, 32'h0);
      check(rd, 32'(g[i] & 8'hBF));
    end
    apb(1'h0, 12'h014, 32'h0);
    check(32'(err), 32'h1);
    $display("regs done");
  endtask : t_regs
  task automatic t_modes;
    logic [1:0] m [4] = '{2'h3, 2'h3, 2'h2, 2'h0};
    logic [23:0] e [4] = '{24'h200000, 24'hE00000, 24'hE00000, 24'h200000};
    foreach (m[i]) begin
      level <= (i == 0);
      apb(1'h1, 12'h004, 32'(m[i]));
      repeat (5) take;
      check(32'(v), 32'(e[i]));
      apb(1'h0, 12'h00C, 32'h0);
      check(32'(rd[23:0]), 32'(e[i]));
    end
    $display("modes done");
  endtask : t_modes
  task automatic t_rate;
    for (int c = 0; c < 4; c++) begin
      apb(1'h1, 12'h004, 32'({c[1:0], 4'h3}));
      repeat (4) take;
      t0 = cyc;
      take;
      check(32'(cyc - t0), 32'h20 << c);
    end
    $display("rate done");
  endtask : t_rate
  task automatic t_buf;
    level <= 1'h1;
    apb(1'h1, 12'h004, 32'h3);
    fast_ready <= 1'h0;
    repeat (300) @(posedge pclk);
    apb(1'h0, 12'h010, 32'h0);
    check(32'(rd[3]), 32'h1);
    fast_ready <= 1'h1;
    repeat (2) begin
      take;
      check(32'(v), 32'h200000);
    end
    $display("buffer done");
  endtask : t_buf
  task automatic t_chop;
    int p = 0;
    int q = 0;
    apb(1'h1, 12'h004, 32'h1);
    // Inverted phase only starts after three slow windows, so span one full pair
    repeat (320) begin
      take;
      p += (v === 24'h200000);
      q += (v === 24'hE00001);
    end
    check(32'(p > 40 && q > 40), 32'h1);
    $display("chop done");
  endtask : t_chop
  task automatic t_slow;
    logic [5:0] s [3] = '{6'h03, 6'h07, 6'h01};
    int w [3] = '{32'h800, 32'h1000, 32'h1000};
    foreach (s[i]) begin
      apb(1'h1, 12'h004, 32'(s[i]));
      repeat (2) wait_slow(t0);
      wait_slow(t1);
      check(32'((t1 - t0 - w[i]) inside {[-16:16]}), 32'h1);
      if (i == 0) check(32'(rd[23:0]), 32'h200000);
    end
    $display("slow done");
  endtask : t_slow
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    level = 1'h1;
    fast_ready = 1'h1;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    apb(1'h1, 12'h000, 32'h93);
    t_modes;
    t_rate;
    t_buf;
    t_chop;
    t_slow;
    summarize;
  end
  // Run needs about 60k cycles; the limit leaves ample slack
  initial begin
    #450000;
    num_errors++;
    summarize;
  end
endmodule : dsdom_top_test

// ===== verilog/dsdom_buf2.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock
// Notes: output side comes straight from flip-flops
module dsdom_buf2 #(
  parameter int WIDTH = 24
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic spare_valid;
  logic [WIDTH-1:0] spare_data;

  assign in_ready = !spare_valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
      spare_valid <= 1'b0;
      spare_data <= '0;
    end else if (out_ready || !out_valid) begin
      if (spare_valid) begin
        out_valid <= 1'b1;
        out_data <= spare_data;
        spare_valid <= 1'b0;
      end else begin
        out_valid <= in_valid;
        if (in_valid) begin
          out_data <= in_data;
        end
      end
    end else if (in_valid && in_ready) begin
      spare_valid <= 1'b1;
      spare_data <= in_data;
    end
  end
endmodule : dsdom_buf2

// ===== verilog/dsdom_consts.svh
// Purpose: register offsets, field positions, reset values and tap ranges for the decimator
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef DSDOM_CONSTS_SVH
`define DSDOM_CONSTS_SVH

`define DSDOM_OFS_GAIN 12'h000
`define DSDOM_OFS_SETUP 12'h004
`define DSDOM_OFS_SLOW 12'h008
`define DSDOM_OFS_FAST 12'h00C
`define DSDOM_OFS_STATUS 12'h010

`define DSDOM_GAIN_RESET 8'h00
`define DSDOM_SETUP_RESET 6'h00

`define DSDOM_ST_SLOW_NEW 0
`define DSDOM_ST_FAST_NEW 1
`define DSDOM_ST_PHASE 2
`define DSDOM_ST_BUF_FULL 3

`define DSDOM_SLOW_LOG2_MIN 11
`define DSDOM_FAST_LOG2_MIN 5
`define DSDOM_POINT_POS 21
`define DSDOM_RESULT_W 24

`endif

// ===== verilog/dsdom_pkg.sv
// Purpose: types shared by the decimator design
// Assumes: field layout as in dsdom_consts.svh
// Notes: nothing here is imported, users write dsdom_pkg::name
package dsdom_pkg;

  typedef enum logic [1:0] {
    DSDOM_MODE_SHORT = 2'h0,
    DSDOM_MODE_CHOP = 2'h1,
    DSDOM_MODE_RAW_ALT = 2'h2,
    DSDOM_MODE_RAW = 2'h3
  } dsdom_mode_t;

  typedef struct packed {
    logic converter_enable;
    logic unused6;
    logic [1:0] ref_gain;
    logic [3:0] input_gain;
  } dsdom_gain_t;

  typedef struct packed {
    logic [1:0] fast_tap_select;
    logic [1:0] slow_tap_select;
    dsdom_mode_t offset_cycle_mode;
  } dsdom_setup_t;

  typedef enum logic {DSDOM_PAIR_POS, DSDOM_PAIR_NEG} dsdom_pair_t;

endpackage : dsdom_pkg

// ===== verilog/dsdom_sinc2.sv
// Purpose: one sinc-squared decimator with selectable tap count
// Assumes: bit_in is the modulator bit, one per clock
// Notes: while the output is stalled, incoming bits are skipped, not summed
`include "dsdom_consts.svh"
module dsdom_sinc2 #(
  parameter int LMIN = 11
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic restart,
  input wire logic [1:0] tap_sel,
  // Modulator bit
  input wire logic bit_in,
  // Result
  output logic out_valid,
  output logic [`DSDOM_RESULT_W-1:0] out_data,
  input wire logic out_ready
);
  localparam int LMAX = LMIN + 3;
  localparam int W = 2 * LMAX + 2;

  logic signed [W-1:0] int1, int2, dly1, dly2;
  logic signed [W-1:0] step, next_comb, next_out;
  logic signed [W+20:0] wide;
  logic [LMAX-1:0] count, last;
  logic [5:0] shift;
  logic [1:0] warm;
  logic stall;

  assign stall = out_valid && !out_ready;
  assign last = {LMAX{1'b1}} >> (2'h3 - tap_sel);
  assign step = {{(W-1){~bit_in}}, 1'b1};
  assign next_comb = int2 - dly1;
  assign next_out = next_comb - dly2;
  assign shift = 6'(2 * LMIN) + {3'h0, tap_sel, 1'b0};
  // Full scale of N squared maps onto one unit at the binary point
  assign wide = $signed({next_out, 21'h0}) >>> shift;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int1 <= '0;
      int2 <= '0;
    end else if (restart) begin
      int1 <= '0;
      int2 <= '0;
    end else if (!stall) begin
      int1 <= int1 + step;
      int2 <= int2 + int1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      dly1 <= '0;
      dly2 <= '0;
      warm <= 2'h0;
      out_valid <= 1'b0;
      out_data <= 24'h000000;
    end else if (restart) begin
      count <= '0;
      dly1 <= '0;
      dly2 <= '0;
      warm <= 2'h0;
      out_valid <= 1'b0;
    end else begin
      if (out_valid && out_ready) begin
        out_valid <= 1'b0;
      end
      if (!stall) begin
        count <= (count == last) ? '0 : count + 1'b1;
        if (count == last) begin
          dly1 <= int2;
          dly2 <= next_comb;
          // Two windows fill the comb stages before a result means anything
          if (warm != 2'h2) begin
            warm <= warm + 2'h1;
          end else begin
            out_valid <= 1'b1;
            out_data <= wide[23:0];
          end
        end
      end
    end
  end
endmodule : dsdom_sinc2

// ===== verilog/dsdom_top.sv
// Purpose: dual sinc-squared decimator with gain path select and offset cycle modes
// Assumes: mod_bit synchronous to pclk; APB slave with one wait state
// Notes: fast results also leave through a two-entry buffer towards peak hold
//
// The APB register port and the address map are this design's own decisions.
`include "dsdom_consts.svh"
module dsdom_top #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Modulator
  input wire logic mod_bit,
  // Analog path controls
  output logic [3:0] input_gain_en,
  output logic [1:0] ref_gain_en,
  output logic converter_enable,
  output logic input_short,
  output logic input_invert,
  // Fast result stream
  output logic fast_valid,
  output logic [`DSDOM_RESULT_W-1:0] fast_data,
  input wire logic fast_ready
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and bus decode

  dsdom_pkg::dsdom_gain_t gain_path_select;
  dsdom_pkg::dsdom_setup_t converter_setup_reg;
  dsdom_pkg::dsdom_pair_t pair_state;
  logic [`DSDOM_RESULT_W-1:0] slow_result;
  logic [`DSDOM_RESULT_W-1:0] fast_result;
  logic [`DSDOM_RESULT_W-1:0] pos_half;
  logic slow_new;
  logic fast_new;
  logic restart;
  logic chop;
  logic access;
  logic wr_done;
  logic rd_done;
  logic [11:0] addr;
  logic [31:0] next_prdata;
  logic next_slverr;
  logic buf_in_ready;

  assign access = psel && penable;
  assign wr_done = access && pready && pwrite;
  assign rd_done = access && pready && !pwrite;
  assign addr = 12'(paddr);
  assign chop = (converter_setup_reg.offset_cycle_mode == dsdom_pkg::DSDOM_MODE_CHOP);

  always_comb begin
    next_prdata = 32'h00000000;
    next_slverr = 1'b0;
    unique case (addr)
      `DSDOM_OFS_GAIN: next_prdata = {24'h000000, gain_path_select & 8'hBF};
      `DSDOM_OFS_SETUP: next_prdata = {26'h0000000, converter_setup_reg};
      `DSDOM_OFS_SLOW: next_prdata = {8'h00, slow_result};
      `DSDOM_OFS_FAST: next_prdata = {8'h00, fast_result};
      `DSDOM_OFS_STATUS: begin
        next_prdata[`DSDOM_ST_SLOW_NEW] = slow_new;
        next_prdata[`DSDOM_ST_FAST_NEW] = fast_new;
        next_prdata[`DSDOM_ST_PHASE] = input_invert;
        next_prdata[`DSDOM_ST_BUF_FULL] = !buf_in_ready;
      end
      default: next_slverr = 1'b1;
    endcase
  end

  // Every access takes one wait state, so pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= access && !pready;
      if (access && !pready) begin
        prdata <= pwrite ? 32'h00000000 : next_prdata;
        pslverr <= next_slverr;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_path_select <= `DSDOM_GAIN_RESET;
    end else if (wr_done && addr == `DSDOM_OFS_GAIN) begin
      gain_path_select <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_setup_reg <= `DSDOM_SETUP_RESET;
    end else if (wr_done && addr == `DSDOM_OFS_SETUP) begin
      converter_setup_reg <= pwdata[5:0];
    end
  end

  // A new tap count or mode invalidates whatever the integrators already hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart <= 1'b1;
    end else begin
      restart <= (wr_done && addr == `DSDOM_OFS_SETUP)
        || !gain_path_select.converter_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Analog path controls

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_gain_en <= 4'h0;
      ref_gain_en <= 2'h0;
      converter_enable <= 1'b0;
      input_short <= 1'b0;
    end else begin
      input_gain_en <= gain_path_select.input_gain;
      ref_gain_en <= gain_path_select.ref_gain;
      converter_enable <= gain_path_select.converter_enable;
      input_short <= converter_setup_reg.offset_cycle_mode
        == dsdom_pkg::DSDOM_MODE_SHORT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Filters

  logic slow_out_valid;
  logic [`DSDOM_RESULT_W-1:0] slow_out_data;
  logic fast_out_valid;
  logic [`DSDOM_RESULT_W-1:0] fast_out_data;
  logic [`DSDOM_RESULT_W-1:0] fast_tagged;
  logic [`DSDOM_RESULT_W:0] pair_diff;

  dsdom_sinc2 #(
    .LMIN(`DSDOM_SLOW_LOG2_MIN)
  ) slow_decimator (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart),
    .tap_sel(converter_setup_reg.slow_tap_select),
    .bit_in(mod_bit),
    .out_valid(slow_out_valid),
    .out_data(slow_out_data),
    .out_ready(1'b1)
  );

  dsdom_sinc2 #(
    .LMIN(`DSDOM_FAST_LOG2_MIN)
  ) fast_decimator (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart),
    .tap_sel(converter_setup_reg.fast_tap_select),
    .bit_in(mod_bit),
    .out_valid(fast_out_valid),
    .out_data(fast_out_data),
    .out_ready(buf_in_ready)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Offset cycle: slow pairing and input polarity

  // Half the difference of the two phases drops the offset term and keeps the input
  assign pair_diff = {pos_half[23], pos_half} - {slow_out_data[23], slow_out_data};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair_state <= dsdom_pkg::DSDOM_PAIR_POS;
      input_invert <= 1'b0;
      pos_half <= 24'h000000;
    end else if (restart || !chop) begin
      pair_state <= dsdom_pkg::DSDOM_PAIR_POS;
      input_invert <= 1'b0;
    end else if (slow_out_valid) begin
      unique case (pair_state)
        dsdom_pkg::DSDOM_PAIR_POS: begin
          pos_half <= slow_out_data;
          input_invert <= 1'b1;
          pair_state <= dsdom_pkg::DSDOM_PAIR_NEG;
        end
        dsdom_pkg::DSDOM_PAIR_NEG: begin
          input_invert <= 1'b0;
          pair_state <= dsdom_pkg::DSDOM_PAIR_POS;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_result <= 24'h000000;
    end else if (slow_out_valid && !restart) begin
      if (!chop) begin
        slow_result <= slow_out_data;
      end else if (pair_state == dsdom_pkg::DSDOM_PAIR_NEG) begin
        slow_result <= pair_diff[24:1];
      end
    end
  end

  // Set wins over the clear by a read in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_new <= 1'b0;
    end else if (slow_out_valid && !restart
      && (!chop || pair_state == dsdom_pkg::DSDOM_PAIR_NEG)) begin
      slow_new <= 1'b1;
    end else if (rd_done && addr == `DSDOM_OFS_SLOW) begin
      slow_new <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fast result and its buffer

  // Bit 0 carries the polarity of the window in mode 01
  assign fast_tagged = chop ? {fast_out_data[23:1], input_invert}
    : fast_out_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_result <= 24'h000000;
    end else if (fast_out_valid && buf_in_ready) begin
      fast_result <= fast_tagged;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_new <= 1'b0;
    end else if (fast_out_valid && buf_in_ready) begin
      fast_new <= 1'b1;
    end else if (rd_done && addr == `DSDOM_OFS_FAST) begin
      fast_new <= 1'b0;
    end
  end

  // A stalled receiver holds the fast filter rather than losing a result
  dsdom_buf2 #(
    .WIDTH(`DSDOM_RESULT_W)
  ) fast_buffer (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(fast_out_valid),
    .in_data(fast_tagged),
    .in_ready(buf_in_ready),
    .out_valid(fast_valid),
    .out_data(fast_data),
    .out_ready(fast_ready)
  );

endmodule : dsdom_top
